// *** dv/e1ls_regs_chk.sv ***
/* port checker of the e1 line register group.
   assumes one clock and software on the plain register port; bound below. */
`timescale 1ns/1ns
`default_nettype none
module e1ls_regs_chk (
  input wire       clk_i,               // clock
  input wire       sys_rst_i,           // sync reset
  input wire [7:0] addr_i,              // address
  input wire [7:0] wr_data_i,           // write data
  input wire       wr_i,                // write strobe
  input wire       rd_i,                // read strobe
  input wire [7:0] rd_data_o,           // read data
  input wire       pulse_sum_ovf_i,     // error event
  input wire       tx_fifo_slip_i,      // error event
  input wire       rx_fifo_slip_i,      // error event
  input wire       excess_zero_i,       // error event
  input wire       code_violation_i,    // error event
  input wire       counter_ovf_i,       // error event
  input wire [4:0] receive_gain_code_i, // gain band
  input wire [3:0] tx_term_sel_o,       // tx one-hot
  input wire       tx_term_bypass_o,    // tx bypass
  input wire [3:0] rx_term_sel_o,       // rx one-hot
  input wire       rx_term_bypass_o,    // rx bypass
  input wire       irq_n_o              // interrupt, low
);
  // ****************
  // enable mirrors
  // ****************
  // enables are internal, so they are rebuilt from the writes
  reg  [7:0] lie_r;
  reg  [7:0] eie_r;
  wire [7:0] ev = {1'b0, pulse_sum_ovf_i, tx_fifo_slip_i, rx_fifo_slip_i, 1'b0, excess_zero_i,
                   code_violation_i, counter_ovf_i};
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      lie_r <= 8'h00;
      eie_r <= 8'h00;
    end
    else if (wr_i)
    begin
      if (addr_i == 8'h33)
        lie_r <= wr_data_i & 8'h05;
      if (addr_i == 8'h34)
        eie_r <= wr_data_i & 8'h77;
    end
  end
  // ****************
  // properties
  // ****************
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_tx_term_decode: assert property (!$past(sys_rst_i) |->
    (tx_term_bypass_o ? tx_term_sel_o == 4'h0 : $onehot(tx_term_sel_o))) else $error("tx select bad");
  a_rx_term_decode: assert property (!$past(sys_rst_i) |->
    (rx_term_bypass_o ? rx_term_sel_o == 4'h0 : $onehot(rx_term_sel_o))) else $error("rx select bad");
  a_err_irq_raise: assert property ((|(ev & eie_r)) && !wr_i |=> !irq_n_o)
    else $error("enabled error gave no interrupt");
  a_irq_all_masked: assert property (!wr_i && lie_r == 8'h00 && eie_r == 8'h00 |=> irq_n_o)
    else $error("interrupt with all enables off");
  a_irq_sticky: assert property (!irq_n_o && !wr_i && !$past(wr_i) |=> !irq_n_o)
    else $error("interrupt dropped without a write");
  a_w1c_release: assert property (wr_i && addr_i == 8'h3B && (eie_r & ~wr_data_i) == 8'h00
    && lie_r == 8'h00 && ev == 8'h00 |=> irq_n_o) else $error("clear left interrupt");
  a_lstat_bits: assert property (rd_i && addr_i == 8'h36 |=> (rd_data_o & 8'hFA) == 8'h00)
    else $error("line state reserved bits set");
  a_gain_live: assert property (rd_i && addr_i == 8'h37 |=>
    rd_data_o == {3'h0, $past(receive_gain_code_i)}) else $error("gain code mismatch");
endmodule // e1ls_regs_chk
bind e1ls_regs e1ls_regs_chk chk (.clk_i, .sys_rst_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
  .pulse_sum_ovf_i, .tx_fifo_slip_i, .rx_fifo_slip_i, .excess_zero_i, .code_violation_i, .counter_ovf_i,
  .receive_gain_code_i, .tx_term_sel_o, .tx_term_bypass_o, .rx_term_sel_o, .rx_term_bypass_o, .irq_n_o);
`default_nettype wire

// *** dv/test_e1_line_status_irq_regs.sv ***
/* bench of the e1 line register group: drives the register port and the
   event inputs, and checks results against its own reckoning.
   assumes the port checker is bound from its own file. */
`timescale 1ns/1ns
`default_nettype none
module test_e1_line_status_irq_regs;
  logic       clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic [7:0] ev = 8'h00;
  logic [7:0] ln = 8'h00;
  logic [7:0] a;
  logic [4:0] gain = 5'h00;
  logic [6:0] dv = 7'h00;
  wire  [6:0] rdv = dv + 7'h01;
  wire  [7:0] rd_data_o;
  wire  [3:0] tsel, rsel;
  wire        tbyp, rbyp, irq_n;
  int         miscompares = 0;
  int         checks = 0;
  int         cyc = 0;
  int         k, x, y, z, mx, mn;
  e1ls_regs uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .driver_fault_i(ln[2]), .signal_loss_i(ln[0]),
    .pulse_sum_ovf_i(ev[6]), .tx_fifo_slip_i(ev[5]), .rx_fifo_slip_i(ev[4]), .excess_zero_i(ev[2]),
    .code_violation_i(ev[1]), .counter_ovf_i(ev[0]), .receive_gain_code_i(gain), .tx_distance_i(dv),
    .rx_distance_i(rdv), .tx_term_sel_o(tsel), .tx_term_bypass_o(tbyp), .rx_term_sel_o(rsel),
    .rx_term_bypass_o(rbyp), .irq_n_o(irq_n));
  // ****************
  // helpers
  // ****************
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      end_sim;
    end
  end
  function automatic logic [7:0] dec(input logic [2:0] c);
    dec = {3'h0, c[2], c[2] ? 4'h0 : 4'h1 << c[1:0]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= ad;
    wr_data_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= ad;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rd_data_o, exp);
  endtask
  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ****************
  // tests
  // ****************
  initial
  begin
    x = $urandom(32'h59087dcf);
    cy(12);
    sys_rst_i <= 1'b0;
    cy(2);
    #1 chk({3'h0, tbyp, tsel}, dec(3'h0));
    chk({3'h0, rbyp, rsel}, dec(3'h7));
    chk({7'h0, irq_n}, 8'h01);
    wr(8'h41, 8'hFF);
    wr(8'h36, 8'hFF);
    rd(8'h32, 8'h07);
    for (k = 8'h33; k < 8'h3C; k++)
      rd(k[7:0], {7'h0, k == 8'h39});
    $display("test reset done");
    // top bits are random: the mask must drop them
    for (k = 0; k < 8; k++)
    begin
      z = 7 - k;
      y = ($urandom & 8'hC0) + z * 8 + k;
      wr(8'h32, y[7:0]);
      cy(2);
      #1 chk({3'h0, tbyp, tsel}, dec(z[2:0]));
      chk({3'h0, rbyp, rsel}, dec(k[2:0]));
      rd(8'h32, y[7:0] & 8'h3F);
    end
    $display("test term done");
    for (k = 0; k < 7; k++)
      if (k != 3)
      begin
        x = $urandom % 2;
        y = x << k;
        wr(8'h34, y[7:0]);
        @(posedge clk_i);
        ev <= 8'h01 << k;
        @(posedge clk_i);
        ev <= 8'h00;
        cy(1);
        #1 chk({7'h0, irq_n}, {7'h0, x == 0});
        rd(8'h3B, 8'h01 << k);
        wr(8'h3B, 8'h01 << k);
        cy(1);
        #1 chk({7'h0, irq_n}, 8'h01);
        rd(8'h3B, 8'h00);
      end
    $display("test error irq done");
    for (k = 0; k < 4; k++)
    begin
      x = k / 2;
      y = k % 2 ? 8'h04 : 8'h01;
      z = $urandom & 8'h05;
      wr(8'h33, z[7:0]);
      wr(8'h35, x ? 8'h05 : 8'h00);
      @(posedge clk_i);
      ln <= y[7:0];
      cy(6);
      rd(8'h36, y[7:0]);
      chk({7'h0, irq_n}, {7'h0, (z & y) == 0});
      rd(8'h3A, y[7:0]);
      wr(8'h3A, y[7:0]);
      @(posedge clk_i);
      ln <= 8'h00;
      cy(6);
      rd(8'h3A, x ? y[7:0] : 8'h00);
      wr(8'h3A, 8'h05);
    end
    $display("test line irq done");
    for (k = 0; k < 4; k++)
    begin
      @(posedge clk_i);
      y = k ? $urandom : 31;
      gain <= y[4:0];
      rd(8'h37, {3'h0, y[4:0]});
    end
    $display("test gain done");
    for (k = 0; k < 2; k++)
    begin
      a = k ? 8'h39 : 8'h38;
      wr(8'h50, 8'h00);
      @(posedge clk_i);
      y = $urandom % 100;
      dv <= y[6:0];
      cy(3);
      rd(a, y[7:0] + k[7:0]);
      wr(8'h50, 8'h01 << k);
      wr(a, 8'h01);
      mx = y;
      mn = y;
      repeat (2)
      begin
        @(posedge clk_i);
        x = $urandom % 100;
        dv <= x[6:0];
        mx = x > mx ? x : mx;
        mn = x < mn ? x : mn;
        cy(3);
      end
      z = mx - mn;
      rd(a, z[7:0]);
      cy(2);
      rd(a, 8'h00);
      @(posedge clk_i);
      dv <= dv ^ 7'h11;
      cy(3);
      wr(a, 8'h01);
      rd(a, 8'h00);
    end
    $display("test jitter done");
    end_sim;
  end
endmodule // test_e1_line_status_irq_regs
`default_nettype wire

// *** verilog/e1ls_defines.vh ***
/*
  constants of the e1 line status and interrupt register group.
  assumes an 8-bit register port; offsets are byte addresses.
*/
`ifndef E1LS_DEFINES_VH
`define E1LS_DEFINES_VH

// ****************************************
// register offsets
// ****************************************
`define E1LS_OFS_TERM      8'h32
`define E1LS_OFS_LINE_IE   8'h33
`define E1LS_OFS_ERR_IE    8'h34
`define E1LS_OFS_EDGE      8'h35
`define E1LS_OFS_LSTAT     8'h36
`define E1LS_OFS_GAIN      8'h37
`define E1LS_OFS_TXJIT     8'h38
`define E1LS_OFS_RXJIT     8'h39
`define E1LS_OFS_LINE_IS   8'h3A
`define E1LS_OFS_ERR_IS    8'h3B
`define E1LS_OFS_JTEST     8'h50

// ****************************************
// field positions
// ****************************************
`define E1LS_B_DF          2
`define E1LS_B_LOS         0
`define E1LS_B_TTERM_LO    3
`define E1LS_B_JTEST_TX    0
`define E1LS_B_JTEST_RX    1
`define E1LS_B_JIT_CLR     0
`define E1LS_LINE_MASK     8'h05
`define E1LS_ERR_MASK      8'h77
`define E1LS_TERM_MASK     8'h3F
`define E1LS_JTEST_MASK    8'h03

// ****************************************
// reset values
// ****************************************
`define E1LS_RST_TERM      8'h07
`define E1LS_RST_ZERO      8'h00
`define E1LS_RST_JMIN      7'h7F

// ****************************************
// termination codes
// ****************************************
`define E1LS_TERM_75       2'h0
`define E1LS_TERM_120      2'h1
`define E1LS_TERM_100      2'h2
`define E1LS_TERM_110      2'h3

`endif

// *** verilog/e1ls_regs.v ***
/*
  register group of one e1 line channel: termination select, line and
  error interrupt enables and status, edge select, line status, receive
  gain code and transmit/receive jitter fifo pointer distance.
  assumes driver fault and signal loss come from another clock domain;
  all other inputs come from logic on clk_i.
*/
// The plain strobed port was chosen for this implementation.
// How it works
// - tx termination code decodes; 1xx bypasses matching
// - rx termination decodes same as transmit
// - line status events need enable for interrupt
// - six error events gated by own enables
// - edge select: rising only or both edges
// - driver fault state readable, live level
// - signal loss state readable, live level
// - five-bit receive gain code readable
// - tx field shows current pointer distance
// - tx test mode shows peak-to-peak since read
// - writing one clears tx jitter field
// - interrupt status bits clear on written one
`timescale 1ns/1ns
`default_nettype none
`include "e1ls_defines.vh"

module e1ls_regs (
  input  wire       clk_i,              // 10 MHz system clock
  input  wire       sys_rst_i,          // synchronous reset, high
  input  wire [7:0] addr_i,             // register address
  input  wire [7:0] wr_data_i,          // write data
  input  wire       wr_i,               // write strobe
  input  wire       rd_i,               // read strobe
  output wire [7:0] rd_data_o,          // read data, cycle after rd_i
  input  wire       driver_fault_i,     // async driver failure level
  input  wire       signal_loss_i,      // async loss of signal level
  input  wire       pulse_sum_ovf_i,    // pulse-sum overflow pulse
  input  wire       tx_fifo_slip_i,     // tx jitter fifo over/underflow
  input  wire       rx_fifo_slip_i,     // rx jitter fifo over/underflow
  input  wire       excess_zero_i,      // excess zero error pulse
  input  wire       code_violation_i,   // code violation pulse
  input  wire       counter_ovf_i,      // error counter overflow pulse
  input  wire [4:0] receive_gain_code_i,// amplifier gain band
  input  wire [6:0] tx_distance_i,      // tx fifo pointer distance
  input  wire [6:0] rx_distance_i,      // rx fifo pointer distance
  output wire [3:0] tx_term_sel_o,      // one-hot 75/120/100/110 ohm
  output wire       tx_term_bypass_o,   // tx internal matching off
  output wire [3:0] rx_term_sel_o,      // one-hot 75/120/100/110 ohm
  output wire       rx_term_bypass_o,   // rx internal matching off
  output wire       irq_n_o             // interrupt, active low
);

  // ****************************************
  // functions
  // ****************************************
  // one-hot impedance select; all zero when bypassed
  function [3:0] term_onehot;
    input [2:0] code;
    begin
      term_onehot = 4'h0;
      if (!code[2])
      begin
        case (code[1:0])
          `E1LS_TERM_75:  term_onehot = 4'h1;
          `E1LS_TERM_120: term_onehot = 4'h2;
          `E1LS_TERM_100: term_onehot = 4'h4;
          `E1LS_TERM_110: term_onehot = 4'h8;
          default:        term_onehot = 4'h0;
        endcase
      end
    end
  endfunction

  // status bit update: hardware set beats software clear
  function [7:0] sticky;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] clr;
    begin
      sticky = (cur & ~clr) | set;
    end
  endfunction

  // window maximum; a restart opens a new window at the present sample
  function [6:0] peak_hi;
    input       restart;
    input [6:0] cur;
    input [6:0] sample;
    begin
      if (restart || (sample > cur))
        peak_hi = sample;
      else
        peak_hi = cur;
    end
  endfunction

  // window minimum, same restart behaviour as the maximum
  function [6:0] peak_lo;
    input       restart;
    input [6:0] cur;
    input [6:0] sample;
    begin
      if (restart || (sample < cur))
        peak_lo = sample;
      else
        peak_lo = cur;
    end
  endfunction

  // measurement field: zero on clear, span in peak mode, else live distance
  function [6:0] jit_field;
    input       clr;
    input       peak;
    input [6:0] hi;
    input [6:0] lo;
    input [6:0] live;
    begin
      if (clr)
        jit_field = 7'h00;
      else if (peak)
        jit_field = hi - lo;
      else
        jit_field = live;
    end
  endfunction

  // ****************************************
  // registers
  // ****************************************
  reg  [7:0] term_r;
  reg  [7:0] line_ie_r;
  reg  [7:0] err_ie_r;
  reg  [7:0] edge_r;
  reg  [7:0] jtest_r;
  reg  [7:0] line_is_r;
  reg  [7:0] err_is_r;
  reg  [7:0] rd_data_r;
  reg  [7:0] rd_data_nxt;
  reg        irq_n_r;
  reg  [3:0] tx_sel_r;
  reg  [3:0] rx_sel_r;
  reg        tx_byp_r;
  reg        rx_byp_r;

  // two-stage synchronisers, then one more stage for edge detection
  reg  [1:0] df_sync_r;
  reg  [1:0] los_sync_r;
  reg        df_prev_r;
  reg        los_prev_r;

  reg  [6:0] tx_meas_r;
  reg  [6:0] tx_max_r;
  reg  [6:0] tx_min_r;
  reg  [6:0] rx_meas_r;
  reg  [6:0] rx_max_r;
  reg  [6:0] rx_min_r;

  wire       df_state  = df_sync_r[1];
  wire       los_state = los_sync_r[1];

  wire       wr_term   = wr_i && (addr_i == `E1LS_OFS_TERM);
  wire       wr_lie    = wr_i && (addr_i == `E1LS_OFS_LINE_IE);
  wire       wr_eie    = wr_i && (addr_i == `E1LS_OFS_ERR_IE);
  wire       wr_edge   = wr_i && (addr_i == `E1LS_OFS_EDGE);
  wire       wr_jtest  = wr_i && (addr_i == `E1LS_OFS_JTEST);
  wire       wr_lis    = wr_i && (addr_i == `E1LS_OFS_LINE_IS);
  wire       wr_eis    = wr_i && (addr_i == `E1LS_OFS_ERR_IS);
  wire       rd_txj    = rd_i && (addr_i == `E1LS_OFS_TXJIT);
  wire       rd_rxj    = rd_i && (addr_i == `E1LS_OFS_RXJIT);

  wire       clr_txj   = wr_i && (addr_i == `E1LS_OFS_TXJIT)
                         && wr_data_i[`E1LS_B_JIT_CLR];
  wire       clr_rxj   = wr_i && (addr_i == `E1LS_OFS_RXJIT)
                         && wr_data_i[`E1LS_B_JIT_CLR];

  wire       tx_pp     = jtest_r[`E1LS_B_JTEST_TX];
  wire       rx_pp     = jtest_r[`E1LS_B_JTEST_RX];

  // ****************************************
  // line status events
  // ****************************************
  wire df_rise  = df_state & ~df_prev_r;
  wire df_fall  = ~df_state & df_prev_r;
  wire los_rise = los_state & ~los_prev_r;
  wire los_fall = ~los_state & los_prev_r;

  wire df_evt  = df_rise | (edge_r[`E1LS_B_DF] & df_fall);
  wire los_evt = los_rise | (edge_r[`E1LS_B_LOS] & los_fall);

  wire [7:0] line_set = {5'h00, df_evt, 1'b0, los_evt};
  wire [7:0] err_set  = {1'b0, pulse_sum_ovf_i, tx_fifo_slip_i,
                         rx_fifo_slip_i, 1'b0, excess_zero_i,
                         code_violation_i, counter_ovf_i};

  wire [7:0] line_clr = wr_lis ? wr_data_i : 8'h00;
  wire [7:0] err_clr  = wr_eis ? wr_data_i : 8'h00;

  wire [7:0] line_is_nxt = sticky(line_is_r, line_set, line_clr)
                           & `E1LS_LINE_MASK;
  wire [7:0] err_is_nxt  = sticky(err_is_r, err_set, err_clr)
                           & `E1LS_ERR_MASK;

  // ****************************************
  // jitter peak-to-peak tracking
  // ****************************************
  // a read or a clear restarts the window at the present distance
  wire tx_restart = rd_txj | clr_txj;
  wire rx_restart = rd_rxj | clr_rxj;

  wire [6:0] tx_max_nxt = peak_hi(tx_restart, tx_max_r, tx_distance_i);
  wire [6:0] tx_min_nxt = peak_lo(tx_restart, tx_min_r, tx_distance_i);
  wire [6:0] rx_max_nxt = peak_hi(rx_restart, rx_max_r, rx_distance_i);
  wire [6:0] rx_min_nxt = peak_lo(rx_restart, rx_min_r, rx_distance_i);

  // live distance in normal mode, window span in test mode
  wire [6:0] tx_meas_nxt = jit_field(clr_txj, tx_pp, tx_max_nxt,
                                     tx_min_nxt, tx_distance_i);
  wire [6:0] rx_meas_nxt = jit_field(clr_rxj, rx_pp, rx_max_nxt,
                                     rx_min_nxt, rx_distance_i);

  // ****************************************
  // interrupt
  // ****************************************
  wire irq_line = |(line_is_nxt & line_ie_r);
  wire irq_err  = |(err_is_nxt & err_ie_r);

  // ****************************************
  // read mux
  // ****************************************
  // unmapped addresses read zero; data stands only after a read
  always @*
  begin
    rd_data_nxt = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        `E1LS_OFS_TERM:    rd_data_nxt = term_r;
        `E1LS_OFS_LINE_IE: rd_data_nxt = line_ie_r;
        `E1LS_OFS_ERR_IE:  rd_data_nxt = err_ie_r;
        `E1LS_OFS_EDGE:    rd_data_nxt = edge_r;
        `E1LS_OFS_LSTAT:   rd_data_nxt = {5'h00, df_state, 1'b0,
                                          los_state};
        `E1LS_OFS_GAIN:    rd_data_nxt = {3'h0,
                                          receive_gain_code_i};
        `E1LS_OFS_TXJIT:   rd_data_nxt = {1'b0, tx_meas_r};
        `E1LS_OFS_RXJIT:   rd_data_nxt = {1'b0, rx_meas_r};
        `E1LS_OFS_LINE_IS: rd_data_nxt = line_is_r;
        `E1LS_OFS_ERR_IS:  rd_data_nxt = err_is_r;
        `E1LS_OFS_JTEST:   rd_data_nxt = jtest_r;
        default:           rd_data_nxt = 8'h00;
      endcase
    end
  end

  // ****************************************
  // synchronisers
  // ****************************************
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      df_sync_r  <= 2'h0;
      los_sync_r <= 2'h0;
      df_prev_r  <= 1'b0;
      los_prev_r <= 1'b0;
    end
    else
    begin
      df_sync_r  <= {df_sync_r[0], driver_fault_i};
      los_sync_r <= {los_sync_r[0], signal_loss_i};
      df_prev_r  <= df_state;
      los_prev_r <= los_state;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      term_r    <= `E1LS_RST_TERM;
      line_ie_r <= `E1LS_RST_ZERO;
      err_ie_r  <= `E1LS_RST_ZERO;
      edge_r    <= `E1LS_RST_ZERO;
      jtest_r   <= `E1LS_RST_ZERO;
    end
    else
    begin
      // tx code top bit must stay writable, else bypass is unreachable
      if (wr_term)
        term_r <= wr_data_i & `E1LS_TERM_MASK;
      if (wr_lie)
        line_ie_r <= wr_data_i & `E1LS_LINE_MASK;
      if (wr_eie)
        err_ie_r <= wr_data_i & `E1LS_ERR_MASK;
      if (wr_edge)
        edge_r <= wr_data_i & `E1LS_LINE_MASK;
      if (wr_jtest)
        jtest_r <= wr_data_i & `E1LS_JTEST_MASK;
    end
  end

  // ****************************************
  // status and interrupt
  // ****************************************
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      line_is_r <= `E1LS_RST_ZERO;
      err_is_r  <= `E1LS_RST_ZERO;
      irq_n_r   <= 1'b1;
    end
    else
    begin
      line_is_r <= line_is_nxt;
      err_is_r  <= err_is_nxt;
      irq_n_r   <= ~(irq_line | irq_err);
    end
  end

  // ****************************************
  // jitter measurement
  // ****************************************
  // the minimum starts at full scale so the first sample always wins
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      tx_meas_r <= 7'h00;
      tx_max_r  <= 7'h00;
      tx_min_r  <= `E1LS_RST_JMIN;
      rx_meas_r <= 7'h00;
      rx_max_r  <= 7'h00;
      rx_min_r  <= `E1LS_RST_JMIN;
    end
    else
    begin
      tx_meas_r <= tx_meas_nxt;
      tx_max_r  <= tx_max_nxt;
      tx_min_r  <= tx_min_nxt;
      rx_meas_r <= rx_meas_nxt;
      rx_max_r  <= rx_max_nxt;
      rx_min_r  <= rx_min_nxt;
    end
  end

  // ****************************************
  // read data and termination outputs
  // ****************************************
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      rd_data_r <= 8'h00;
      tx_sel_r  <= 4'h0;
      rx_sel_r  <= 4'h0;
      tx_byp_r  <= 1'b0;
      rx_byp_r  <= 1'b0;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
      tx_sel_r  <= term_onehot(term_r[`E1LS_B_TTERM_LO +: 3]);
      tx_byp_r  <= term_r[`E1LS_B_TTERM_LO + 2];
      rx_sel_r  <= term_onehot(term_r[2:0]);
      rx_byp_r  <= term_r[2];
    end
  end

  assign rd_data_o        = rd_data_r;
  assign irq_n_o          = irq_n_r;
  assign tx_term_sel_o    = tx_sel_r;
  assign tx_term_bypass_o = tx_byp_r;
  assign rx_term_sel_o    = rx_sel_r;
  assign rx_term_bypass_o = rx_byp_r;

endmodule // e1ls_regs

`default_nettype wire
